// ---- cmp_pkg.sv ----
// Functional notes
// - register writes follow array write sequence with own slave id and one address byte
// - read data starts from current register pointer on next serial clock
// - register pointer increments after every byte, like the array pointer
// - array and register pointers are independent; loading one keeps the other
// - current-address array read resumes where array pointer stopped
// - array address two bytes msb first; top bits beyond density ignored
// - register address above 18h gets nack and transaction is abandoned
// - array pointer increments before acknowledge and wraps to zero
// - master ack requests next byte; nack, stop or start ends read
package cmp_pkg;
    localparam logic [3:0] mem_id      = 4'ha;
    localparam logic [3:0] reg_id      = 4'hd;
    localparam logic [7:0] reg_last    = 8'h18;
    localparam logic [7:0] reg_ptr_rst = 8'h00;
    localparam logic [14:0] mem_ptr_rst = 15'h0000;
    localparam logic [14:0] mem_mask_64  = 15'h1fff;
    localparam logic [14:0] mem_mask_256 = 15'h7fff;

    typedef enum logic [2:0] {
        st_idle  = 3'b000,
        st_dev   = 3'b001,
        st_adr_h = 3'b010,
        st_adr_l = 3'b011,
        st_wdata = 3'b100,
        st_rdata = 3'b101,
        st_ign   = 3'b110
    } bus_state_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic        is_reg;
        logic [14:0] addr;
        logic [7:0]  wdata;
    } mem_req_t;
endpackage

// ---- cmp_i2c_addr.sv ----
`timescale 1ns/10ps
module cmp_i2c_addr (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              scl,
    input  wire logic              sda_in,
    input  wire logic [1:0]        dev_sel,
    input  wire logic              big_array,
    input  wire logic [7:0]        rdata,
    output logic                   sda_out,
    output logic                   sda_oe,
    output cmp_pkg::mem_req_t      req,
    output logic [14:0]            mem_ptr_out,
    output logic [7:0]             reg_ptr_out
);
    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rs1, rs2;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rs1 <= 1'b0;
            rs2 <= 1'b0;
        end else begin
            rs1 <= 1'b1;
            rs2 <= rs1;
        end
    end
    wire rst_n = rs2;

    // ----------------------------------------------------------------
    // bus condition detection (inputs taken as synchronous)
    // ----------------------------------------------------------------
    logic scl_d, sda_d;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl;
            sda_d <= sda_in;
        end
    end
    wire scl_rise = scl & ~scl_d;
    wire scl_fall = ~scl & scl_d;
    wire start_c  = scl & scl_d & sda_d & ~sda_in;
    wire stop_c   = scl & scl_d & ~sda_d & sda_in;

    // ----------------------------------------------------------------
    // byte engine
    // ----------------------------------------------------------------
    cmp_pkg::bus_state_t state;
    logic [3:0]  bitcnt;
    logic [7:0]  shreg;
    logic [7:0]  txreg;
    logic        sel_reg;
    logic        ack_ph;
    logic [14:0] mem_ptr;
    logic [7:0]  reg_ptr;
    logic [6:0]  adr_hi;
    logic        mack;

    wire [7:0]  rx_byte  = {shreg[6:0], sda_d};
    // a byte the device sends is not one it takes: no device acknowledge then
    wire        byte_end = scl_rise && bitcnt == 4'd7 && !ack_ph
                           && state != cmp_pkg::st_rdata;
    wire        id_mem   = rx_byte[7:4] == cmp_pkg::mem_id && rx_byte[2:1] == dev_sel;
    wire        id_reg   = rx_byte[7:4] == cmp_pkg::reg_id && rx_byte[2:1] == dev_sel;
    wire [14:0] mask     = big_array ? cmp_pkg::mem_mask_256 : cmp_pkg::mem_mask_64;
    wire [14:0] new_madr = {adr_hi, rx_byte} & mask;
    wire        reg_bad  = rx_byte > cmp_pkg::reg_last;
    wire [14:0] mem_inc  = (mem_ptr + 15'h0001) & mask;
    wire        rd_phase = state == cmp_pkg::st_rdata;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state   <= cmp_pkg::st_idle;
            bitcnt  <= 4'h0;
            shreg   <= 8'h00;
            txreg   <= 8'h00;
            sel_reg <= 1'b0;
            ack_ph  <= 1'b0;
            mem_ptr <= cmp_pkg::mem_ptr_rst;
            reg_ptr <= cmp_pkg::reg_ptr_rst;
            adr_hi  <= 7'h00;
            mack    <= 1'b0;
            sda_out <= 1'b0;
            sda_oe  <= 1'b0;
            req     <= '0;
            mem_ptr_out <= cmp_pkg::mem_ptr_rst;
            reg_ptr_out <= cmp_pkg::reg_ptr_rst;
        end else begin
            req.wr <= 1'b0;
            req.rd <= 1'b0;
            mem_ptr_out <= mem_ptr;
            reg_ptr_out <= reg_ptr;
            if (start_c) begin
                // repeated start aborts a write; pointers survive
                state  <= cmp_pkg::st_dev;
                bitcnt <= 4'h0;
                ack_ph <= 1'b0;
                sda_oe <= 1'b0;
            end else if (stop_c) begin
                state  <= cmp_pkg::st_idle;
                sda_oe <= 1'b0;
            end else if (state != cmp_pkg::st_idle && state != cmp_pkg::st_ign) begin
                if (scl_rise && !ack_ph) begin
                    shreg  <= rx_byte;
                    bitcnt <= bitcnt + 4'h1;
                end
                if (scl_rise && ack_ph) begin
                    mack <= ~sda_d;
                end
                if (byte_end) begin
                    ack_ph <= 1'b1;
                    case (state)
                        cmp_pkg::st_dev: begin
                            if (!(id_mem || id_reg)) begin
                                state <= cmp_pkg::st_ign;
                            end else begin
                                sel_reg <= id_reg;
                                if (rx_byte[0]) begin
                                    state   <= cmp_pkg::st_rdata;
                                    req.rd  <= 1'b1;
                                    req.is_reg <= id_reg;
                                    req.addr <= id_reg ? {7'h00, reg_ptr} : mem_ptr;
                                end else if (id_reg) begin
                                    state <= cmp_pkg::st_adr_l;
                                end else begin
                                    state <= cmp_pkg::st_adr_h;
                                end
                            end
                        end
                        cmp_pkg::st_adr_h: begin
                            adr_hi <= rx_byte[6:0];
                            state  <= cmp_pkg::st_adr_l;
                        end
                        cmp_pkg::st_adr_l: begin
                            if (sel_reg) begin
                                // only the register pointer moves
                                if (reg_bad) begin
                                    state <= cmp_pkg::st_ign;
                                end else begin
                                    reg_ptr <= rx_byte;
                                    state   <= cmp_pkg::st_wdata;
                                end
                            end else begin
                                mem_ptr <= new_madr;
                                state   <= cmp_pkg::st_wdata;
                            end
                        end
                        cmp_pkg::st_wdata: begin
                            req.wr     <= 1'b1;
                            req.is_reg <= sel_reg;
                            req.addr   <= sel_reg ? {7'h00, reg_ptr} : mem_ptr;
                            req.wdata  <= rx_byte;
                            if (sel_reg) begin
                                reg_ptr <= reg_ptr + 8'h01;
                            end else begin
                                mem_ptr <= mem_inc;
                            end
                        end
                        default: begin
                            state <= cmp_pkg::st_ign;
                        end
                    endcase
                end
                if (rd_phase && scl_rise && bitcnt == 4'd7 && !ack_ph) begin
                    // byte sent: advance pointer before the master's acknowledge
                    if (sel_reg) begin
                        reg_ptr <= reg_ptr + 8'h01;
                    end else begin
                        mem_ptr <= mem_inc;
                    end
                end
                if (scl_fall) begin
                    if (ack_ph && bitcnt == 4'd8) begin
                        // ninth clock: the device acknowledges every byte it takes
                        sda_oe  <= 1'b1;
                        sda_out <= 1'b0;
                        bitcnt  <= 4'd9;
                    end else if (ack_ph && bitcnt == 4'd9) begin
                        ack_ph <= 1'b0;
                        bitcnt <= 4'h0;
                        if (rd_phase) begin
                            // read address acknowledged: first data bit follows
                            txreg   <= rdata;
                            sda_out <= rdata[7];
                        end else begin
                            sda_oe <= 1'b0;
                        end
                    end else if (rd_phase && !ack_ph && bitcnt != 4'd0) begin
                        if (bitcnt == 4'd8) begin
                            sda_oe <= 1'b0;
                            ack_ph <= 1'b1;
                            bitcnt <= 4'd10;
                        end else begin
                            sda_out <= txreg[3'd7 - bitcnt[2:0]];
                        end
                    end else if (rd_phase && ack_ph && bitcnt == 4'd10) begin
                        if (mack) begin
                            req.rd     <= 1'b1;
                            req.is_reg <= sel_reg;
                            req.addr   <= sel_reg ? {7'h00, reg_ptr} : mem_ptr;
                            ack_ph     <= 1'b0;
                            bitcnt     <= 4'd11;
                        end else begin
                            state <= cmp_pkg::st_ign;
                        end
                    end
                end
                if (rd_phase && bitcnt == 4'd11) begin
                    // rdata answers one cycle after the request pulse, so wait one
                    bitcnt <= 4'd12;
                end
                if (rd_phase && bitcnt == 4'd12) begin
                    txreg   <= rdata;
                    sda_oe  <= 1'b1;
                    sda_out <= rdata[7];
                    bitcnt  <= 4'h0;
                end
            end else begin
                sda_oe <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    bad_reg_nack_a: assert property (@(posedge clk) disable iff (!rst_n)
        (byte_end && state == cmp_pkg::st_adr_l && sel_reg && reg_bad)
        |=> state == cmp_pkg::st_ign && !sda_oe)
        else $error("register address above limit was not refused");
    ptr_indep_a: assert property (@(posedge clk) disable iff (!rst_n)
        (sel_reg && state != cmp_pkg::st_dev) |=> $stable(mem_ptr) || !sel_reg)
        else $error("array pointer moved during register access");
    mem_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mem_ptr == mask && byte_end && state == cmp_pkg::st_wdata && !sel_reg)
        |=> mem_ptr == 15'h0000)
        else $error("array pointer did not wrap");
    reg_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!sel_reg && state != cmp_pkg::st_dev) |=> $stable(reg_ptr))
        else $error("register pointer moved during array access");
    reg_inc_a: assert property (@(posedge clk) disable iff (!rst_n)
        (byte_end && state == cmp_pkg::st_wdata && sel_reg)
        |=> reg_ptr == $past(reg_ptr) + 8'h01)
        else $error("register pointer did not advance after a write");
    read_start_a: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_phase && scl_fall && ack_ph && bitcnt == 4'd9)
        |=> sda_oe && sda_out == $past(rdata[7]))
        else $error("read data did not start after the address");
    nack_end_a: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_phase && scl_fall && ack_ph && bitcnt == 4'd10 && !mack)
        |=> state == cmp_pkg::st_ign && !sda_oe)
        else $error("read went on after a refused byte");
endmodule

// ---- cmp_master_model.sv ----
`timescale 1ns/10ps
module cmp_master_model (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    // ------------------------------------------
    // bus master, open-drain on sda with pull-up; scl driven high and low directly
    // ------------------------------------------
    localparam int quarter = 5;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic pause();
        repeat (quarter) @(posedge clk);
    endtask

    // sda moves only while scl is low, apart from the two framing conditions
    task automatic start_cond();
        sda_low <= 1'b0;
        pause();
        scl <= 1'b1;
        pause();
        sda_low <= 1'b1;
        pause();
        scl <= 1'b0;
        pause();
    endtask

    task automatic stop_cond();
        sda_low <= 1'b1;
        pause();
        scl <= 1'b1;
        pause();
        sda_low <= 1'b0;
        pause();
        pause();
    endtask

    // nine bits msb first; a released bit reads back what the device drives
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            sda_low <= ~tx[i];
            pause();
            scl <= 1'b1;
            pause();
            rx[i] = sda;
            pause();
            scl <= 1'b0;
            pause();
        end
    endtask
endmodule

// ---- companion_i2c_address_pointers_bench.sv ----
`timescale 1ns/10ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
    $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module companion_i2c_address_pointers_bench;
    logic              clk = 1'b0;
    logic              rst_b = 1'b0;
    logic [1:0]        dev_sel = 2'h0;
    logic              big_array = 1'b1;
    logic [7:0]        rdata = 8'h00;
    logic              sda_out, sda_oe, scl, sda_low, sda;
    cmp_pkg::mem_req_t req;
    cmp_pkg::mem_req_t writes[$];
    logic [14:0]       mem_ptr_out, mem_exp, a;
    logic [7:0]        reg_ptr_out, reg_exp, r;
    int                n_errors = 0;
    int                checks_done = 0;

    always #4 clk = ~clk;
    // wired-and line: a low from either party wins over the pull-up
    assign sda = ~sda_low & ~(sda_oe & ~sda_out);

    cmp_i2c_addr i_dut (.clk(clk), .rst_b(rst_b), .scl(scl), .sda_in(sda), .dev_sel(dev_sel),
        .big_array(big_array), .rdata(rdata), .sda_out(sda_out), .sda_oe(sda_oe), .req(req),
        .mem_ptr_out(mem_ptr_out), .reg_ptr_out(reg_ptr_out));
    cmp_master_model i_master (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

    // ------------------------------------------
    // storage behind the block and expectations
    // ------------------------------------------
    function automatic logic [7:0] data_of(input logic is_reg, input logic [14:0] ad);
        return ad[7:0] ^ {1'b0, ad[14:8]} ^ (is_reg ? 8'h5a : 8'h00);
    endfunction
    function automatic logic [14:0] msk();
        return big_array ? cmp_pkg::mem_mask_256 : cmp_pkg::mem_mask_64;
    endfunction
    always @(posedge clk) begin
        if (req.rd) rdata <= data_of(req.is_reg, req.addr);
        if (req.wr) writes.push_back(req);
    end

    task automatic send(input logic [7:0] b, input logic ack_exp);
        logic [8:0] rx;
        i_master.xfer({b, 1'b1}, rx);
        `CHK(rx[0], ~ack_exp)
    endtask
    task automatic set_ptr(input logic is_reg, input logic [15:0] ad);
        i_master.start_cond();
        send({is_reg ? cmp_pkg::reg_id : cmp_pkg::mem_id, 1'b0, dev_sel, 1'b0}, 1'b1);
        if (!is_reg) send(ad[15:8], 1'b1);
        send(ad[7:0], is_reg ? ad[7:0] <= cmp_pkg::reg_last : 1'b1);
    endtask
    task automatic write_run(input logic is_reg, input int n);
        logic [7:0] d;
        cmp_pkg::mem_req_t w;
        for (int k = 0; k < n; k++) begin
            d = 8'($urandom);
            send(d, 1'b1);
            w = writes.pop_front();
            `CHK(w, {2'b10, is_reg, is_reg ? {7'h00, reg_exp} : mem_exp, d})
            if (is_reg) reg_exp++;
            else mem_exp = (mem_exp + 15'h1) & msk();
        end
    endtask
    // current-address read; the last byte is refused to end the read
    task automatic read_run(input logic is_reg, input int n);
        logic [8:0] rx;
        i_master.start_cond();
        send({is_reg ? cmp_pkg::reg_id : cmp_pkg::mem_id, 1'b0, dev_sel, 1'b1}, 1'b1);
        for (int k = 0; k < n; k++) begin
            i_master.xfer({8'hff, k == n - 1}, rx);
            if (is_reg) begin
                `CHK(rx[8:1], data_of(1'b1, {7'h00, reg_exp}))
                reg_exp++;
            end else begin
                `CHK(rx[8:1], data_of(1'b0, mem_exp))
                mem_exp = (mem_exp + 15'h1) & msk();
            end
        end
        i_master.stop_cond();
        `CHK(mem_ptr_out, mem_exp)
        `CHK(reg_ptr_out, reg_exp)
    endtask

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (95000) @(posedge clk);
        n_errors++;
        print_verdict();
    end

    // ------------------------------------------
    // scenarios
    // ------------------------------------------
    initial begin
        void'($urandom(32'h86fda094));
        @(posedge clk);
        dev_sel <= 2'($urandom);
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (5) @(posedge clk);
        reg_exp = cmp_pkg::reg_ptr_rst;
        set_ptr(1'b0, 16'hfffe); // top bit ignored, wrap to zero
        mem_exp = 15'h7ffe;
        read_run(1'b0, 3);
        set_ptr(1'b1, 16'h0017);
        reg_exp = 8'h17;
        read_run(1'b1, 2); // last valid register, array pointer untouched
        read_run(1'b0, 2); // array read resumes
        set_ptr(1'b1, 16'h0019); // out of range, refused
        i_master.stop_cond();
        i_master.start_cond();
        send({cmp_pkg::mem_id, 1'b0, ~dev_sel, 1'b0}, 1'b0);
        i_master.stop_cond();
        read_run(1'b0, 1);
        for (int t = 0; t < 6; t++) begin
            big_array <= 1'($urandom);
            // first pass starts at the top address so a write wraps
            a = (t == 0) ? 15'h7fff : 15'($urandom);
            r = 8'($urandom_range(0, 24));
            set_ptr(1'b0, {1'($urandom), a});
            mem_exp = a & msk();
            write_run(1'b0, 2);
            set_ptr(1'b1, {8'h00, r});
            reg_exp = r;
            write_run(1'b1, 1);
            read_run(1'b1, 2);
            read_run(1'b0, 2);
        end
        print_verdict();
    end
endmodule
